// >>> logic/fsq_flash.sv
`timescale 1ns/10ps
module fsq_flash
    import fsq_pkg::*;
#(
    parameter int SECT_W   = 10,
    parameter int MEM_AW   = 10,
    parameter int BUSY_CYC = 32
) (
    // clock and resets
    input  wire logic       clock,
    input  wire logic       rst_b,
    input  wire logic       nv_rst_b,
    // serial link pins
    input  wire logic       select_low,
    input  wire logic       serial_clock,
    input  wire logic       data_in,
    output logic            data_out,
    output logic            data_oe_b,
    // state view
    output logic            wide_mode,
    output logic [7:0]      status
);

    localparam int CNT_W = ((MEM_AW > $clog2(BUSY_CYC + 1)) ?
                            MEM_AW : $clog2(BUSY_CYC + 1)) + 1;
    localparam logic [CNT_W-1:0] CNT_ONE   = CNT_W'(1);
    localparam logic [CNT_W-1:0] BUSY_LAST = CNT_W'(BUSY_CYC - 1);
    localparam logic [CNT_W-1:0] MEM_LAST  = CNT_W'((1 << MEM_AW) - 1);
    localparam logic [SECT_W:0]  SECT_ONE  = (SECT_W + 1)'(1);
    localparam int PROG_MAX  = BUSY_CYC + 1;

    if (SECT_W < 1 || SECT_W > 16 || MEM_AW < 2 || MEM_AW > 26 ||
        BUSY_CYC < 2 || BUSY_CYC > 999) begin : g_bad_param
        $error("fsq_flash: unsupported parameter values");
    end

    // protection level to sector hit, both start sides
    function automatic logic prot_hit(input logic [SECT_W-1:0] sec,
                                      input logic [3:0]        lvl,
                                      input logic              bottom);
        logic [SECT_W:0] span;
        logic [SECT_W:0] idx;
        logic            hit;
        span = '0;
        idx  = {1'b0, sec};
        hit  = 1'b0;
        if (lvl == 4'h0) begin
            hit = 1'b0;
        end else if (int'(lvl) - 1 >= SECT_W) begin
            hit = 1'b1;
        end else begin
            span = SECT_ONE << (lvl - 4'h1);
            if (bottom) begin
                hit = idx < span;
            end else begin
                hit = idx >= ((SECT_ONE << SECT_W) - span);
            end
        end
        return hit;
    endfunction

    // pin synchronisers; the link clock is sampled, not used as a clock
    logic [1:0] cs_sync_reg;
    logic [1:0] sck_sync_reg;
    logic [1:0] din_sync_reg;
    logic       cs_dly_reg;
    logic       sck_dly_reg;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cs_sync_reg  <= 2'h3;
            sck_sync_reg <= 2'h0;
            din_sync_reg <= 2'h0;
            cs_dly_reg   <= 1'b1;
            sck_dly_reg  <= 1'b0;
        end else begin
            cs_sync_reg  <= {cs_sync_reg[0], select_low};
            sck_sync_reg <= {sck_sync_reg[0], serial_clock};
            din_sync_reg <= {din_sync_reg[0], data_in};
            cs_dly_reg   <= cs_sync_reg[1];
            sck_dly_reg  <= sck_sync_reg[1];
        end
    end

    logic cs_low;
    logic cs_rise;
    logic sck_rise;
    logic sck_fall;
    assign cs_low   = ~cs_sync_reg[1];
    assign cs_rise  = cs_sync_reg[1] & ~cs_dly_reg;
    assign sck_rise = sck_sync_reg[1] & ~sck_dly_reg & cs_low;
    assign sck_fall = ~sck_sync_reg[1] & sck_dly_reg & cs_low;

    // frame state
    fsq_frame_e  st_reg, st_next;
    logic [7:0]  sh_reg, sh_next;
    logic [2:0]  bit_reg, bit_next;
    logic [7:0]  opc_reg, opc_next;
    logic [31:0] addr_reg, addr_next;
    logic [2:0]  abyte_reg, abyte_next;
    logic        addr_ok_reg, addr_ok_next;
    logic        data_ok_reg, data_ok_next;
    logic [7:0]  wdata_reg, wdata_next;
    logic        stat_rd_reg, stat_rd_next;
    logic [7:0]  tx_reg, tx_next;
    logic [2:0]  txbit_reg, txbit_next;
    logic        dout_reg, dout_next;
    logic        doe_b_reg, doe_b_next;

    // core state
    fsq_job_e         job_reg, job_next;
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic [5:0]       cfg_reg, cfg_next;
    logic             wel_reg, wel_next;
    logic             wip_reg, wip_next;
    logic             wide_reg, wide_next;

    logic [7:0]        status_byte;
    logic [3:0]        lvl;
    logic [7:0]        new_byte;
    logic [31:0]       addr_cat;
    logic [2:0]        nbytes;
    logic [7:0]        tx_src;
    logic              tx_msb;
    logic              rd_en;
    logic [MEM_AW-1:0] rd_addr;
    logic [7:0]        rd_data;
    logic              prot_now;
    logic              exec_ok;

    assign status_byte = {cfg_reg, wel_reg, wip_reg};
    assign lvl = {status_byte[ST_LVL3], status_byte[ST_LVL2],
                  status_byte[ST_LVL1], status_byte[ST_LVL0]};
    assign new_byte = {sh_reg[6:0], din_sync_reg[1]};
    assign addr_cat = {addr_reg[23:0], new_byte};
    assign nbytes   = wide_reg ? WIDE_BYTES : NARROW_BYTES;
    assign tx_src   = stat_rd_reg ? status_byte : rd_data;
    assign tx_msb   = tx_src[7];
    // sector index of the latched address
    assign prot_now = prot_hit(addr_reg[SECT_SHIFT +: SECT_W], lvl,
                               status_byte[ST_START]);

    always_comb begin
        st_next      = st_reg;
        sh_next      = sh_reg;
        bit_next     = bit_reg;
        opc_next     = opc_reg;
        addr_next    = addr_reg;
        abyte_next   = abyte_reg;
        addr_ok_next = addr_ok_reg;
        data_ok_next = data_ok_reg;
        wdata_next   = wdata_reg;
        stat_rd_next = stat_rd_reg;
        tx_next      = tx_reg;
        txbit_next   = txbit_reg;
        dout_next    = dout_reg;
        doe_b_next   = doe_b_reg;
        rd_en        = 1'b0;
        rd_addr      = addr_reg[MEM_AW-1:0];
        if (st_reg == F_IDLE) begin
            if (cs_low) begin
                st_next      = F_OPC;
                bit_next     = 3'h0;
                abyte_next   = 3'h0;
                // a frame without clocks must not replay the last opcode
                opc_next     = 8'h00;
                addr_next    = '0;
                addr_ok_next = 1'b0;
                data_ok_next = 1'b0;
                stat_rd_next = 1'b0;
                txbit_next   = 3'h0;
            end
        end else begin
            if (sck_rise) begin
                sh_next  = new_byte;
                bit_next = bit_reg + 3'h1;
            end
            if (sck_rise && bit_reg == LAST_BIT) begin
                if (st_reg == F_OPC) begin
                    opc_next = new_byte;
                    if (new_byte == OP_STATUS_RD) begin
                        st_next      = F_DOUT;
                        stat_rd_next = 1'b1;
                    end else if (wip_reg) begin
                        st_next = F_SKIP;
                    end else if (new_byte == OP_READ ||
                                 new_byte == OP_PROGRAM ||
                                 new_byte == OP_SECT_ERASE ||
                                 new_byte == OP_SUB_ERASE) begin
                        st_next = F_ADDR;
                    end else if (new_byte == OP_STATUS_WR) begin
                        st_next = F_DIN;
                    end else begin
                        st_next = F_SKIP;
                    end
                end else if (st_reg == F_ADDR) begin
                    addr_next  = addr_cat;
                    abyte_next = abyte_reg + 3'h1;
                    if (abyte_reg + 3'h1 == nbytes) begin
                        addr_ok_next = 1'b1;
                        if (opc_reg == OP_READ) begin
                            st_next = F_DOUT;
                            rd_en   = 1'b1;
                            rd_addr = addr_cat[MEM_AW-1:0];
                        end else if (opc_reg == OP_PROGRAM) begin
                            st_next = F_DIN;
                        end else begin
                            st_next = F_SKIP;
                        end
                    end
                end else if (st_reg == F_DIN) begin
                    // single byte program; later bytes are ignored
                    wdata_next   = new_byte;
                    data_ok_next = 1'b1;
                    st_next      = F_SKIP;
                end
            end
            if (sck_fall && st_reg == F_DOUT) begin
                doe_b_next = 1'b0;
                if (txbit_reg == 3'h0) begin
                    dout_next  = tx_msb;
                    tx_next    = {tx_src[6:0], 1'b0};
                    txbit_next = LAST_BIT;
                    if (!stat_rd_reg) begin
                        addr_next = addr_reg + 32'h0000_0001;
                        rd_en     = 1'b1;
                        rd_addr   = addr_next[MEM_AW-1:0];
                    end
                end else begin
                    dout_next  = tx_reg[7];
                    tx_next    = {tx_reg[6:0], 1'b0};
                    txbit_next = txbit_reg - 3'h1;
                end
            end
            if (cs_rise) begin
                st_next    = F_IDLE;
                doe_b_next = 1'b1;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            st_reg      <= F_IDLE;
            sh_reg      <= 8'h00;
            bit_reg     <= 3'h0;
            opc_reg     <= 8'h00;
            addr_reg    <= 32'h0000_0000;
            abyte_reg   <= 3'h0;
            addr_ok_reg <= 1'b0;
            data_ok_reg <= 1'b0;
            wdata_reg   <= 8'h00;
            stat_rd_reg <= 1'b0;
            tx_reg      <= 8'h00;
            txbit_reg   <= 3'h0;
            dout_reg    <= 1'b0;
            doe_b_reg   <= 1'b1;
        end else begin
            st_reg      <= st_next;
            sh_reg      <= sh_next;
            bit_reg     <= bit_next;
            opc_reg     <= opc_next;
            addr_reg    <= addr_next;
            abyte_reg   <= abyte_next;
            addr_ok_reg <= addr_ok_next;
            data_ok_reg <= data_ok_next;
            wdata_reg   <= wdata_next;
            stat_rd_reg <= stat_rd_next;
            tx_reg      <= tx_next;
            txbit_reg   <= txbit_next;
            dout_reg    <= dout_next;
            doe_b_reg   <= doe_b_next;
        end
    end

    // write, erase and mode commands act only on deselect at a byte boundary, never while busy
    assign exec_ok = cs_rise & (st_reg != F_IDLE) & (bit_reg == 3'h0) &
                     ~wip_reg;

    always_comb begin
        job_next  = job_reg;
        cnt_next  = cnt_reg;
        cfg_next  = cfg_reg;
        wel_next  = wel_reg;
        wip_next  = wip_reg;
        wide_next = wide_reg;
        if (job_reg == J_IDLE) begin
            if (exec_ok) begin
                cnt_next = '0;
                if (opc_reg == OP_WRITE_PERMIT) begin
                    wel_next = 1'b1;
                end else if (opc_reg == OP_WRITE_FORBID) begin
                    wel_next = 1'b0;
                end else if (opc_reg == OP_ENTER_WIDE) begin
                    wide_next = 1'b1;
                end else if (opc_reg == OP_EXIT_WIDE) begin
                    wide_next = 1'b0;
                end else if (opc_reg == OP_PROGRAM && data_ok_reg &&
                             wel_reg && !prot_now) begin
                    job_next = J_PROG;
                    wip_next = 1'b1;
                end else if (opc_reg == OP_STATUS_WR && data_ok_reg &&
                             wel_reg) begin
                    cfg_next = wdata_reg[ST_SPARE:ST_LVL0];
                    job_next = J_STATUS;
                    wip_next = 1'b1;
                end else if ((opc_reg == OP_SECT_ERASE ||
                              opc_reg == OP_SUB_ERASE) && addr_ok_reg &&
                             wel_reg && !prot_now) begin
                    job_next = J_ERASE;
                    wip_next = 1'b1;
                end else if ((opc_reg == OP_BULK_ERASE ||
                              opc_reg == OP_DIE_ERASE) && wel_reg &&
                             lvl == 4'h0) begin
                    job_next = J_ERASE;
                    wip_next = 1'b1;
                end
            end
        end else begin
            cnt_next = cnt_reg + CNT_ONE;
            if ((job_reg != J_ERASE && cnt_reg == BUSY_LAST) ||
                (job_reg == J_ERASE && cnt_reg == MEM_LAST)) begin
                job_next = J_IDLE;
                wip_next = 1'b0;
                wel_next = 1'b0;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            job_reg <= J_IDLE;
            cnt_reg <= '0;
            cfg_reg <= CFG_RESET;
            wel_reg <= FLAG_RESET;
            wip_reg <= FLAG_RESET;
        end else begin
            job_reg <= job_next;
            cnt_reg <= cnt_next;
            cfg_reg <= cfg_next;
            wel_reg <= wel_next;
            wip_reg <= wip_next;
        end
    end

    // wide mode survives rst_b, standing in for a power cycle
    always_ff @(posedge clock or negedge nv_rst_b) begin
        if (!nv_rst_b) begin
            wide_reg <= 1'b0;
        end else begin
            wide_reg <= wide_next;
        end
    end

    // the model array aliases the full address space
    fsq_mem #(
        .AW (MEM_AW),
        .DW (8)
    ) u_mem (
        .clock   (clock),
        .rst_b   (rst_b),
        .wr_en   ((job_reg == J_PROG && cnt_reg == '0) ||
                  job_reg == J_ERASE),
        .wr_addr ((job_reg == J_ERASE) ? cnt_reg[MEM_AW-1:0] :
                                         addr_reg[MEM_AW-1:0]),
        .wr_data ((job_reg == J_ERASE) ? ERASED_BYTE : wdata_reg),
        .rd_en   (rd_en),
        .rd_addr (rd_addr),
        .rd_data (rd_data)
    );

    assign data_out  = dout_reg;
    assign data_oe_b = doe_b_reg;
    assign wide_mode = wide_reg;
    assign status    = status_byte;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    property p_start_boundary;
        $rose(wip_reg) |-> $past(bit_reg) == 3'h0 && $past(cs_rise);
    endproperty
    a_start_boundary: assert property (p_start_boundary)
        else $error("cycle started off a byte boundary");

    property p_start_permit;
        $rose(wip_reg) |-> $past(wel_reg);
    endproperty
    a_start_permit: assert property (p_start_permit)
        else $error("cycle started without write permit");

    property p_prog_unprotected;
        $rose(wip_reg) && job_reg == J_PROG |-> !$past(prot_now);
    endproperty
    a_prog_unprotected: assert property (p_prog_unprotected)
        else $error("program ran inside protected region");

    property p_bulk_levels;
        $rose(wip_reg) && ($past(opc_reg) == OP_BULK_ERASE ||
                           $past(opc_reg) == OP_DIE_ERASE)
            |-> $past(lvl) == 4'h0;
    endproperty
    a_bulk_levels: assert property (p_bulk_levels)
        else $error("bulk erase ran with protection set");

    property p_prog_time;
        $rose(wip_reg) && job_reg == J_PROG
            |-> wip_reg [*2] ##[1:PROG_MAX] !wip_reg;
    endproperty
    a_prog_time: assert property (p_prog_time)
        else $error("program busy time wrong");

    property p_busy_no_read;
        st_reg == F_DOUT && !stat_rd_reg |-> !wip_reg;
    endproperty
    a_busy_no_read: assert property (p_busy_no_read)
        else $error("memory read while cycle running");

    property p_busy_job_kept;
        wip_reg && !exec_ok && $stable(job_reg) |=> $stable(cfg_reg);
    endproperty
    a_busy_job_kept: assert property (p_busy_job_kept)
        else $error("status changed during running cycle");

    property p_wide_enter;
        disable iff (!rst_b || !nv_rst_b)
        $rose(wide_reg) |-> $past(opc_reg) == OP_ENTER_WIDE;
    endproperty
    a_wide_enter: assert property (p_wide_enter)
        else $error("wide mode set without enter command");

    property p_wide_exit;
        disable iff (!rst_b || !nv_rst_b)
        $fell(wide_reg) |-> $past(opc_reg) == OP_EXIT_WIDE;
    endproperty
    a_wide_exit: assert property (p_wide_exit)
        else $error("wide mode cleared without exit command");

    property p_msb_first;
        sck_fall && st_reg == F_DOUT && txbit_reg == 3'h0 && !cs_rise
            |=> data_out == $past(tx_msb) && !data_oe_b;
    endproperty
    a_msb_first: assert property (p_msb_first)
        else $error("first output bit is not the msb");

    property p_deselect_ends;
        cs_rise |=> st_reg == F_IDLE && data_oe_b;
    endproperty
    a_deselect_ends: assert property (p_deselect_ends)
        else $error("deselect did not end the frame");

    c_status_read: cover property (st_reg == F_DOUT && stat_rd_reg &&
                                   sck_fall);
    c_program: cover property ($rose(wip_reg) && job_reg == J_PROG);
    c_bulk: cover property ($rose(wip_reg) && job_reg == J_ERASE);
    c_wide: cover property ($rose(wide_reg));

endmodule // fsq_flash

// >>> logic/fsq_mem.sv
`timescale 1ns/10ps
module fsq_mem #(
    parameter int AW = 10,
    parameter int DW = 8
) (
    // clock and reset
    input  wire logic          clock,
    input  wire logic          rst_b,
    // write port
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [DW-1:0] wr_data,
    // read port
    input  wire logic          rd_en,
    input  wire logic [AW-1:0] rd_addr,
    output logic      [DW-1:0] rd_data
);

    logic [DW-1:0] store [0:(1<<AW)-1];
    logic [DW-1:0] rd_data_reg;

    if (AW < 1 || DW < 1) begin : g_bad_size
        $error("fsq_mem: size parameters out of range");
    end

    // array content is not reset, as in a real cell array
    always_ff @(posedge clock) begin
        if (wr_en) begin
            store[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rd_data_reg <= '0;
        end else if (rd_en) begin
            rd_data_reg <= store[rd_addr];
        end
    end

    assign rd_data = rd_data_reg;

endmodule // fsq_mem

// >>> logic/fsq_pkg.sv
package fsq_pkg;

    // operation codes
    localparam logic [7:0] OP_WRITE_PERMIT = 8'h06;
    localparam logic [7:0] OP_WRITE_FORBID = 8'h04;
    localparam logic [7:0] OP_READ         = 8'h03;
    localparam logic [7:0] OP_PROGRAM      = 8'h02;
    localparam logic [7:0] OP_STATUS_WR    = 8'h01;
    localparam logic [7:0] OP_STATUS_RD    = 8'h05;
    localparam logic [7:0] OP_SECT_ERASE   = 8'hD8;
    localparam logic [7:0] OP_SUB_ERASE    = 8'h20;
    localparam logic [7:0] OP_BULK_ERASE   = 8'hC7;
    localparam logic [7:0] OP_DIE_ERASE    = 8'hC4;
    localparam logic [7:0] OP_ENTER_WIDE   = 8'hB7;
    localparam logic [7:0] OP_EXIT_WIDE    = 8'hE9;

    // status register layout
    localparam int ST_SPARE = 7;
    localparam int ST_LVL3  = 6;
    localparam int ST_START = 5;
    localparam int ST_LVL2  = 4;
    localparam int ST_LVL1  = 3;
    localparam int ST_LVL0  = 2;
    localparam int ST_WEL   = 1;
    localparam int ST_WIP   = 0;
    localparam logic [5:0] CFG_RESET  = 6'h00;
    localparam logic       FLAG_RESET = 1'b0;

    // address framing and geometry
    localparam logic [2:0] NARROW_BYTES = 3'h3;
    localparam logic [2:0] WIDE_BYTES   = 3'h4;
    localparam logic [2:0] LAST_BIT     = 3'h7;
    localparam int         SECT_SHIFT   = 16;
    localparam int         SUB_SHIFT    = 12;
    localparam logic [7:0] ERASED_BYTE  = 8'hFF;

    typedef enum logic [2:0] {
        F_IDLE,
        F_OPC,
        F_ADDR,
        F_DIN,
        F_DOUT,
        F_SKIP
    } fsq_frame_e;

    typedef enum logic [1:0] {
        J_IDLE,
        J_PROG,
        J_STATUS,
        J_ERASE
    } fsq_job_e;

endpackage

// >>> verification/fsq_host.sv
`timescale 1ns/10ps
module fsq_host (
    // clock
    input  wire logic clock,
    // link pins
    output logic      select_low,
    output logic      serial_clock,
    output logic      data_in,
    input  wire logic data_out,
    input  wire logic data_oe_b
);
    logic oe_seen;

    initial begin
        select_low   = 1'b1;
        serial_clock = 1'b0;
        data_in      = 1'b0;
        oe_seen      = 1'b0;
    end

    // nb bits out, then nr bits in; clock idles low between frames
    task automatic xfer(input logic [47:0] tx, input int nb,
                        input int nr, output logic [7:0] rx);
        rx = 8'h00;
        oe_seen = 1'b1;
        @(posedge clock);
        select_low <= 1'b0;
        for (int i = 0; i < nb + nr; i++) begin
            serial_clock <= 1'b0;
            if (i < nb)
                data_in <= tx[47-i];
            else
                data_in <= ~data_in;
            repeat (10) @(posedge clock);
            serial_clock <= 1'b1;
            if (i >= nb) begin
                rx = {rx[6:0], data_out};
                if (data_oe_b !== 1'b0)
                    oe_seen = 1'b0;
            end
            repeat (10) @(posedge clock);
        end
        serial_clock <= 1'b0;
        repeat (5) @(posedge clock);
        select_low <= 1'b1;
        data_in    <= ~data_in;
        // leave time for execute and the busy flag to show
        repeat (8) @(posedge clock);
    endtask
endmodule // fsq_host

// >>> verification/tb_fsq_flash.sv
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin \
    error_cnt++; $display("[FAIL] %s expected %h seen %h", nm, exp, got); \
    end end
module tb_fsq_flash
    import fsq_pkg::*;
;
    logic       clock;
    logic       rst_b;
    logic       nv_rst_b;
    logic       select_low;
    logic       serial_clock;
    logic       data_in;
    logic       data_out;
    logic       data_oe_b;
    logic       wide_mode;
    logic [7:0] status;
    logic [7:0] rx;
    int         error_cnt;
    int         checks;

    fsq_flash #(.SECT_W(10), .MEM_AW(4), .BUSY_CYC(800)) i_dut (
        .clock(clock), .rst_b(rst_b), .nv_rst_b(nv_rst_b),
        .select_low(select_low), .serial_clock(serial_clock),
        .data_in(data_in), .data_out(data_out), .data_oe_b(data_oe_b),
        .wide_mode(wide_mode), .status(status));

    fsq_host i_host (
        .clock(clock), .select_low(select_low),
        .serial_clock(serial_clock), .data_in(data_in),
        .data_out(data_out), .data_oe_b(data_oe_b));

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    task automatic finish_test();
        if (error_cnt == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic op(input logic [47:0] tx, input int nb, input int nr);
        i_host.xfer(tx, nb, nr, rx);
    endtask

    // bounded wait for the busy flag to clear
    task automatic wait_idle();
        int n;
        n = 0;
        while (status[ST_WIP] !== 1'b0 && n < 2000) begin
            @(posedge clock);
            n++;
        end
        if (n == 2000) begin
            error_cnt++;
            finish_test();
        end
    endtask

    initial begin
        rst_b = 1'b0;
        nv_rst_b = 1'b0;
        error_cnt = 0;
        checks = 0;
        repeat (8) @(posedge clock);
        rst_b <= 1'b1;
        nv_rst_b <= 1'b1;
        repeat (8) @(posedge clock);
        `CHK("status", 8'h00, status)
        `CHK("wide", 1'b0, wide_mode)
        op({OP_WRITE_PERMIT, 40'h0}, 8, 0);
        op({OP_STATUS_RD, 40'h0}, 8, 8);
        `CHK("rd_status", 8'h02, rx)
        `CHK("oe_read", 1'b1, i_host.oe_seen)
        `CHK("oe_idle", 1'b1, data_oe_b)
        op({OP_STATUS_WR, 8'hE4, 32'h0}, 16, 0);
        `CHK("wip", 1'b1, status[ST_WIP])
        op({OP_STATUS_RD, 40'h0}, 8, 8);
        `CHK("busy_status", 8'hE7, rx)
        op({OP_ENTER_WIDE, 40'h0}, 8, 0);
        `CHK("busy_wide", 1'b0, wide_mode)
        wait_idle();
        `CHK("status", 8'hE4, status)
        // bottom start, code 9: die erase and program to sector 0 both refused
        op({OP_WRITE_PERMIT, 40'h0}, 8, 0);
        op({OP_DIE_ERASE, 40'h0}, 8, 0);
        `CHK("die_wip", 1'b0, status[ST_WIP])
        op({OP_PROGRAM, 24'h00_0005, 8'hA5, 8'h00}, 40, 0);
        `CHK("prot_wip", 1'b0, status[ST_WIP])
        op({OP_STATUS_WR, 8'h00, 32'h0}, 16, 0);
        wait_idle();
        op({OP_WRITE_PERMIT, 40'h0}, 8, 0);
        op({OP_PROGRAM, 24'h00_0005, 8'hA5, 8'h00}, 39, 0);
        `CHK("part_wip", 1'b0, status[ST_WIP])
        op({OP_PROGRAM, 24'h00_0005, 8'hA5, 8'h00}, 40, 0);
        `CHK("prog_wip", 1'b1, status[ST_WIP])
        wait_idle();
        `CHK("status", 8'h00, status)
        op({OP_READ, 24'h00_0005, 16'h0}, 32, 8);
        `CHK("read", 8'hA5, rx)
        op({OP_ENTER_WIDE, 40'h0}, 8, 0);
        `CHK("wide", 1'b1, wide_mode)
        @(posedge clock);
        rst_b <= 1'b0;
        repeat (2) @(posedge clock);
        rst_b <= 1'b1;
        repeat (8) @(posedge clock);
        `CHK("wide_kept", 1'b1, wide_mode)
        op({OP_READ, 32'h0000_0005, 8'h0}, 40, 8);
        `CHK("read_wide", 8'hA5, rx)
        // top start, code 10: upper half protected, sector 0 free
        op({OP_WRITE_PERMIT, 40'h0}, 8, 0);
        op({OP_STATUS_WR, 8'h48, 32'h0}, 16, 0);
        wait_idle();
        `CHK("status_top", 8'h48, status)
        op({OP_WRITE_PERMIT, 40'h0}, 8, 0);
        op({OP_WRITE_FORBID, 40'h0}, 8, 0);
        op({OP_SUB_ERASE, 32'h0000_1000, 8'h0}, 40, 0);
        `CHK("forbid_wip", 1'b0, status[ST_WIP])
        op({OP_WRITE_PERMIT, 40'h0}, 8, 0);
        op({OP_PROGRAM, 32'h03FF_0005, 8'h3C}, 48, 0);
        `CHK("top_wip", 1'b0, status[ST_WIP])
        op({OP_SECT_ERASE, 32'h03FF_0000, 8'h0}, 40, 0);
        `CHK("sect_wip", 1'b0, status[ST_WIP])
        op({OP_SUB_ERASE, 32'h0000_1000, 8'h0}, 40, 0);
        `CHK("sub_wip", 1'b1, status[ST_WIP])
        wait_idle();
        op({OP_WRITE_PERMIT, 40'h0}, 8, 0);
        op({OP_PROGRAM, 32'h0000_0005, 8'h3C}, 48, 0);
        `CHK("low_wip", 1'b1, status[ST_WIP])
        wait_idle();
        op({OP_READ, 32'h0000_0005, 8'h0}, 40, 8);
        `CHK("read_3c", 8'h3C, rx)
        op({OP_WRITE_PERMIT, 40'h0}, 8, 0);
        op({OP_STATUS_WR, 8'h00, 32'h0}, 16, 0);
        wait_idle();
        op({OP_EXIT_WIDE, 40'h0}, 8, 0);
        `CHK("wide", 1'b0, wide_mode)
        op({OP_WRITE_PERMIT, 40'h0}, 8, 0);
        op({OP_BULK_ERASE, 40'h0}, 8, 0);
        `CHK("bulk_wip", 1'b1, status[ST_WIP])
        wait_idle();
        op({OP_READ, 24'h00_0005, 16'h0}, 32, 8);
        `CHK("erased", ERASED_BYTE, rx)
        finish_test();
    end
endmodule // tb_fsq_flash
